// >>> logic/i2sp_dev.sv
// Memory device end of the two-wire link: address match, page writes,
// counter-based reads and the internal nonvolatile write period.
// Assumes the host drives the serial clock, starts and stops.
module i2sp_dev #(
  parameter int MEM_AW = i2sp_pkg::MEM_AW,
  parameter int NVW_CYCLES = i2sp_pkg::NVW_CYCLES
) (
  input wire logic clk,    // Core clock
  input wire logic arst_n, // Asynchronous reset, active low
  i2sp_if.dev link,        // Two-wire link
  output logic nv_busy,    // Nonvolatile write in progress
  output logic nv_commit   // Pulse when a commit completes
);

  localparam int MEM_N = 1 << MEM_AW;

  // Synchronisers and previous synced levels
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;

  // Link state
  i2sp_pkg::i2sp_dev_st_e state_q;
  logic [i2sp_pkg::CNT_W-1:0] cnt_q;
  logic ack_q;
  logic rw_q;
  logic [7:0] sr_q;
  logic oe_q;

  // Memory and write tracking
  logic [MEM_AW-1:0] ptr_q;
  logic [7:0] mem_q [MEM_N];
  logic dirty_q;
  logic busy_q;
  logic [i2sp_pkg::NVW_W-1:0] busy_cnt_q;
  logic commit_q;

  // Bus events
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic fall_w;
  logic byte_end_w;
  logic accept_w;
  logic [7:0] rd_byte_w;
  logic maddr_take_w;
  logic wdata_take_w;
  logic rd_adv_w;

  // Two flip-flops on each pin before use
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end
    else
    begin
      scl_m_q <= link.scl;
      scl_s_q <= scl_m_q;
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
    end
  end

  // Previous synced levels for edge detection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Start, stop and clock edges
  assign start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_w = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign rise_w = scl_s_q & ~scl_p_q;
  assign fall_w = ~scl_s_q & scl_p_q;
  assign byte_end_w = fall_w & ~ack_q & (cnt_q == i2sp_pkg::BYTE_BITS);

  // Address byte accepted only on match and when idle inside
  assign accept_w = (state_q != i2sp_pkg::D_ADDR) ||
                    ((sr_q[7:1] == i2sp_pkg::DEV_ADDR) && !busy_q);

  // Byte under the counter for reads
  assign rd_byte_w = mem_q[ptr_q];

  // Counter and memory update strobes
  assign maddr_take_w = (state_q == i2sp_pkg::D_MADDR) && byte_end_w;
  assign wdata_take_w = (state_q == i2sp_pkg::D_WDATA) && byte_end_w;
  assign rd_adv_w = (state_q == i2sp_pkg::D_READ) && rise_w && ack_q && !sda_s_q;

  // Link sequencer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= i2sp_pkg::D_IDLE;
      cnt_q <= '0;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      sr_q <= 8'h00;
      oe_q <= 1'b0;
    end
    else if (start_w)
    begin
      state_q <= i2sp_pkg::D_ADDR;
      cnt_q <= '0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (stop_w)
    begin
      state_q <= i2sp_pkg::D_IDLE;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        i2sp_pkg::D_ADDR, i2sp_pkg::D_MADDR, i2sp_pkg::D_WDATA:
        begin
          if (rise_w && !ack_q && (cnt_q < i2sp_pkg::BYTE_BITS))
          begin
            sr_q <= {sr_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 1'b1;
          end
          else if (byte_end_w)
          begin
            ack_q <= accept_w;
            oe_q <= accept_w;
            if (state_q == i2sp_pkg::D_ADDR)
            begin
              rw_q <= sr_q[0];
            end
            if (!accept_w)
            begin
              state_q <= i2sp_pkg::D_IDLE;
            end
          end
          else if (fall_w && ack_q)
          begin
            ack_q <= 1'b0;
            cnt_q <= '0;
            if (state_q == i2sp_pkg::D_ADDR && rw_q)
            begin
              state_q <= i2sp_pkg::D_READ;
              oe_q <= ~rd_byte_w[7];
            end
            else
            begin
              oe_q <= 1'b0;
              state_q <= (state_q == i2sp_pkg::D_ADDR) ? i2sp_pkg::D_MADDR :
                         i2sp_pkg::D_WDATA;
            end
          end
        end
        i2sp_pkg::D_READ:
        begin
          if (fall_w && !ack_q)
          begin
            if (cnt_q == i2sp_pkg::BYTE_BITS)
            begin
              oe_q <= 1'b0;
              ack_q <= 1'b1;
            end
            else
            begin
              oe_q <= ~rd_byte_w[~cnt_q[2:0]];
            end
          end
          else if (rise_w && !ack_q && (cnt_q < i2sp_pkg::BYTE_BITS))
          begin
            cnt_q <= cnt_q + 1'b1;
          end
          else if (rise_w && ack_q)
          begin
            ack_q <= 1'b0;
            cnt_q <= '0;
            if (sda_s_q)
            begin
              state_q <= i2sp_pkg::D_IDLE;
            end
          end
        end
        default:
        begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Address counter: load, row wrap on write, advance on read ack
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ptr_q <= '0;
    end
    else if (maddr_take_w)
    begin
      ptr_q <= sr_q[MEM_AW-1:0];
    end
    else if (wdata_take_w)
    begin
      ptr_q <= {ptr_q[MEM_AW-1:i2sp_pkg::ROW_AW],
                ptr_q[i2sp_pkg::ROW_AW-1:0] + 1'b1};
    end
    else if (rd_adv_w)
    begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // Byte store
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < MEM_N; i++)
      begin
        mem_q[i] <= 8'h00;
      end
    end
    else if (wdata_take_w)
    begin
      mem_q[ptr_q] <= sr_q;
    end
  end

  // Pending commit: set by data, dropped by a repeated start
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dirty_q <= 1'b0;
    end
    else if (wdata_take_w)
    begin
      dirty_q <= 1'b1;
    end
    else if (start_w || stop_w)
    begin
      dirty_q <= 1'b0;
    end
  end

  // Nonvolatile write period after a stop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
      commit_q <= 1'b0;
    end
    else
    begin
      commit_q <= 1'b0;
      if (stop_w && dirty_q)
      begin
        busy_q <= 1'b1;
        busy_cnt_q <= i2sp_pkg::NVW_W'(NVW_CYCLES - 1);
      end
      else if (busy_q)
      begin
        if (busy_cnt_q == '0)
        begin
          busy_q <= 1'b0;
          commit_q <= 1'b1;
        end
        else
        begin
          busy_cnt_q <= busy_cnt_q - 1'b1;
        end
      end
    end
  end

  // Open-drain data pin
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_q;
  assign nv_busy = busy_q;
  assign nv_commit = commit_q;

endmodule : i2sp_dev

// >>> shared/i2sp_pkg.sv
// Shared constants and types for the two-wire page access link.
// Assumes a single 125 MHz core clock on both ends.
package i2sp_pkg;

  // Bus address of the memory device, write form 8'hd6
  localparam logic [6:0] DEV_ADDR = 7'h6b;

  // Memory geometry: a row is eight bytes
  localparam int ROW_AW = 3;
  localparam int MEM_AW = 6;

  // Core clock and link timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_MHZ = 125;
  localparam int LINK_PERIOD_NS = 160;
  localparam int QTR_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QTR_W = 3;

  // Internal nonvolatile write time and its cycle count
  localparam int NVW_TIME_US = 10;
  localparam int NVW_CYCLES = NVW_TIME_US * CLK_MHZ;
  localparam int NVW_W = 16;

  // Bit counter width and the count that closes a byte
  localparam int CNT_W = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Device link states
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_MADDR = 3'b010,
    D_WDATA = 3'b011,
    D_READ = 3'b100
  } i2sp_dev_st_e;

  // Host sequencer states
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BITS = 2'b10,
    H_STOP = 2'b11
  } i2sp_host_st_e;

  // Host byte-level operations
  typedef enum logic [2:0] {
    OP_START = 3'b000,
    OP_WRITE = 3'b001,
    OP_READ_ACK = 3'b010,
    OP_READ_NACK = 3'b011,
    OP_STOP = 3'b100
  } i2sp_op_e;

endpackage : i2sp_pkg

// >>> shared/i2sp_if.sv
// Two-wire link between the bus master and the memory device.
// Assumes an external pull-up: the data wire is high unless an end pulls it low.
interface i2sp_if;
  logic scl;        // Serial clock, driven by the host
  logic host_sda_o; // Host data out (always low)
  logic host_sda_oe; // Host pulls data low
  logic dev_sda_o;  // Device data out (always low)
  logic dev_sda_oe; // Device pulls data low
  logic sda;        // Resolved data wire level

  // Wired-AND with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : i2sp_if

// >>> logic/i2sp_host.sv
// Bus master end of the two-wire link: byte-level start, write, read and
// stop operations, with a two-entry buffer on the read data path.
// Assumes its user orders operations; the serial clock is made here.
module i2sp_host #(
  parameter int QTR_CYC = i2sp_pkg::QTR_CYC
) (
  input wire logic clk,         // Core clock
  input wire logic arst_n,      // Asynchronous reset, active low
  i2sp_if.host link,            // Two-wire link
  input wire logic cmd_valid,   // Operation offered
  output logic cmd_ready,       // Operation taken when high with valid
  input wire logic [2:0] cmd_op, // Operation code
  input wire logic [7:0] cmd_data, // Byte for a write
  output logic done,            // Pulse when an operation ends
  output logic got_nack,        // Last written byte not acknowledged
  output logic rd_valid,        // Read byte available
  input wire logic rd_ready,    // Read byte consumed
  output logic [7:0] rd_data    // Read byte
);

  logic [i2sp_pkg::QTR_W-1:0] div_q;
  logic tick_w;
  i2sp_pkg::i2sp_host_st_e state_q;
  logic [1:0] ph_q;
  logic [i2sp_pkg::CNT_W-1:0] bit_q;
  logic [8:0] tx_q;
  logic [8:0] rx_q;
  logic is_rd_q;
  logic scl_q;
  logic oe_q;
  logic ready_q;
  logic done_q;
  logic nack_q;
  logic sda_m_q;
  logic sda_s_q;
  logic take_w;
  logic fin_w;
  logic push_w;
  logic pop_w;
  logic [7:0] head_q;
  logic [7:0] tail_q;
  logic head_v_q;
  logic tail_v_q;

  // Quarter-bit enable divider
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      div_q <= '0;
    else
      div_q <= tick_w ? '0 : div_q + 1'b1;
  end
  assign tick_w = (div_q == i2sp_pkg::QTR_W'(QTR_CYC - 1));

  // Data wire synchroniser
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end
    else
    begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
    end
  end

  assign take_w = cmd_valid & ready_q;
  assign fin_w = tick_w && (ph_q == 2'b11) && (state_q != i2sp_pkg::H_IDLE) &&
                 ((state_q != i2sp_pkg::H_BITS) || (bit_q == i2sp_pkg::BYTE_BITS));
  assign push_w = fin_w && (state_q == i2sp_pkg::H_BITS) && is_rd_q;
  assign pop_w = head_v_q & rd_ready;

  // Operation sequencer; every pin change lands on a quarter tick
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= i2sp_pkg::H_IDLE;
      ph_q <= 2'b00;
      bit_q <= '0;
      tx_q <= 9'h1ff;
      rx_q <= 9'h000;
      is_rd_q <= 1'b0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
    end
    else if (take_w)
    begin
      ph_q <= 2'b00;
      bit_q <= '0;
      is_rd_q <= (cmd_op == i2sp_pkg::OP_READ_ACK) || (cmd_op == i2sp_pkg::OP_READ_NACK);
      case (cmd_op)
        i2sp_pkg::OP_START: state_q <= i2sp_pkg::H_START;
        i2sp_pkg::OP_STOP: state_q <= i2sp_pkg::H_STOP;
        i2sp_pkg::OP_WRITE:
        begin
          state_q <= i2sp_pkg::H_BITS;
          tx_q <= {cmd_data, 1'b1};
        end
        i2sp_pkg::OP_READ_ACK:
        begin
          state_q <= i2sp_pkg::H_BITS;
          tx_q <= 9'h1fe;
        end
        default:
        begin
          state_q <= i2sp_pkg::H_BITS;
          tx_q <= 9'h1ff;
        end
      endcase
    end
    else if (tick_w && state_q != i2sp_pkg::H_IDLE)
    begin
      ph_q <= ph_q + 1'b1;
      case (ph_q)
        2'b00: scl_q <= 1'b0;
        2'b01: oe_q <= (state_q == i2sp_pkg::H_BITS) ? ~tx_q[8] :
                       (state_q == i2sp_pkg::H_STOP);
        2'b10: scl_q <= 1'b1;
        default:
        begin
          if (state_q == i2sp_pkg::H_START)
            oe_q <= 1'b1;
          else if (state_q == i2sp_pkg::H_STOP)
            oe_q <= 1'b0;
          else
          begin
            rx_q <= {rx_q[7:0], sda_s_q};
            tx_q <= {tx_q[7:0], 1'b1};
            bit_q <= bit_q + 1'b1;
          end
          if (fin_w)
            state_q <= i2sp_pkg::H_IDLE;
        end
      endcase
    end
  end

  // Command handshake and results
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end
    else
    begin
      ready_q <= (state_q == i2sp_pkg::H_IDLE) && !take_w && !tail_v_q;
      done_q <= fin_w;
      if (fin_w && state_q == i2sp_pkg::H_BITS && !is_rd_q)
        nack_q <= sda_s_q;
    end
  end

  // Two-entry read buffer; when full no new operation starts, so SCL stalls
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      head_q <= 8'h00;
      tail_q <= 8'h00;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end
    else if (pop_w)
    begin
      if (tail_v_q)
      begin
        head_q <= tail_q;
        tail_v_q <= push_w;
        if (push_w)
          tail_q <= rx_q[7:0];
      end
      else if (push_w)
        head_q <= rx_q[7:0];
      else
        head_v_q <= 1'b0;
    end
    else if (push_w)
    begin
      if (!head_v_q)
      begin
        head_q <= rx_q[7:0];
        head_v_q <= 1'b1;
      end
      else
      begin
        tail_q <= rx_q[7:0];
        tail_v_q <= 1'b1;
      end
    end
  end

  // Pins and outputs; data is open-drain
  assign link.scl = scl_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_q;
  assign cmd_ready = ready_q;
  assign done = done_q;
  assign got_nack = nack_q;
  assign rd_valid = head_v_q;
  assign rd_data = head_q;

endmodule : i2sp_host

// >>> tb/i2sp_monitor.sv
// Checker for the two-wire link between the host and device ends.
// Assumes it sits beside the interface, clocked by the core clock.
module i2sp_monitor #(
  parameter int NVW_CYCLES = i2sp_pkg::NVW_CYCLES
) (
  input wire logic clk, // Core clock
  input wire logic arst_n, // Reset, active low
  input wire logic scl, // Serial clock
  input wire logic sda, // Resolved data wire
  input wire logic dev_sda_o, // Device data out
  input wire logic dev_sda_oe, // Device pulls data low
  input wire logic nv_busy, // Write period running
  input wire logic nv_commit // Write period ended
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] busy_cnt_q;
  logic [3:0] since_stop_q;
  logic sda_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Length of the current busy period
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      busy_cnt_q <= 16'h0000;
    else
      busy_cnt_q <= nv_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
  end

  // Cycles since the last stop, saturating
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_q <= 1'b1;
      since_stop_q <= 4'hf;
    end
    else
    begin
      sda_q <= sda;
      if (scl && sda && !sda_q)
        since_stop_q <= 4'h0;
      else if (since_stop_q != 4'hf)
        since_stop_q <= since_stop_q + 4'h1;
    end
  end

  sequence busy_end_s;
    nv_busy ##1 !nv_busy;
  endsequence

  busy_len_a: assert property ($fell(nv_busy) |-> int'(busy_cnt_q) == NVW_CYCLES)
    else $error("write period length wrong");
  commit_end_a: assert property (busy_end_s |-> ##[0:1] nv_commit)
    else $error("no commit after write period");
  commit_cause_a: assert property (nv_commit |-> $past(nv_busy))
    else $error("commit without write period");
  commit_pulse_a: assert property (nv_commit |=> !nv_commit)
    else $error("commit longer than one cycle");
  busy_quiet_a: assert property (nv_busy |-> !dev_sda_oe)
    else $error("device drives data while busy");
  dev_od_a: assert property (dev_sda_oe |-> dev_sda_o == 1'b0)
    else $error("device drives data high");
  dev_edge_a: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device changes data with clock high");
  stop_first_a: assert property ($rose(nv_busy) |-> since_stop_q != 4'hf)
    else $error("write period without stop");
  scl_low_a: assert property ($fell(scl) |=> !scl [*8])
    else $error("serial clock low phase too short");
endmodule : i2sp_monitor

// >>> tb/testbench.sv
// Bench joining host and device ends across the two-wire link.
// Assumes package, interface and both ends are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int NVW = 400;
  localparam logic [7:0] WA = {i2sp_pkg::DEV_ADDR, 1'b0};
  localparam logic [7:0] RA = {i2sp_pkg::DEV_ADDR, 1'b1};
  localparam logic [2:0] ST = i2sp_pkg::OP_START;
  localparam logic [2:0] SP = i2sp_pkg::OP_STOP;
  localparam logic [2:0] RK = i2sp_pkg::OP_READ_ACK;
  localparam logic [2:0] RN = i2sp_pkg::OP_READ_NACK;
  logic clk, arst_n, cmd_valid, cmd_ready, done, got_nack, rd_valid, rd_ready;
  logic nv_busy, nv_commit, busy_seen;
  logic [2:0] cmd_op;
  logic [7:0] cmd_data, rd_data;
  logic [7:0] mem [64];
  logic [7:0] rq [$];
  int n_fail, n_compared, polls;

  i2sp_if link ();
  i2sp_host u_i2sp_host (.clk(clk), .arst_n(arst_n), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .done(done), .got_nack(got_nack), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data));
  i2sp_dev #(.NVW_CYCLES(NVW)) u_i2sp_dev (.clk(clk), .arst_n(arst_n), .link(link.dev),
    .nv_busy(nv_busy), .nv_commit(nv_commit));
  i2sp_monitor #(.NVW_CYCLES(NVW)) u_i2sp_monitor (.clk(clk), .arst_n(arst_n),
    .scl(link.scl), .sda(link.sda), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .nv_busy(nv_busy), .nv_commit(nv_commit));

  // Core clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Collect read bytes and note write periods
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      rq.push_back(rd_data);
    if (nv_busy === 1'b1)
      busy_seen = 1'b1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] pop();
    return (rq.size() > 0) ? rq.pop_front() : 8'hxx;
  endfunction : pop

  // One host operation: offer, wait for take, wait for done
  task automatic op(input logic [2:0] o, input logic [7:0] d);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_data = d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 5000);
    #1 cmd_valid = 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 400);
    #1;
    if (n >= 400)
      check(8'h00, 8'h01);
  endtask : op

  task automatic wb(input logic [7:0] d, input logic nack);
    op(i2sp_pkg::OP_WRITE, d);
    check({7'h00, got_nack}, {7'h00, nack});
  endtask : wb

  // Burst of n bytes from address a; the model wraps inside the row
  task automatic burst(input logic [5:0] a, input int n, input logic [7:0] b0);
    op(ST, 8'h00);
    wb(WA, 1'b0);
    wb({2'b00, a}, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      wb(8'(b0 + 8'h11 * i), 1'b0);
      mem[{a[5:3], 3'(a[2:0] + 3'(i))}] = 8'(b0 + 8'h11 * i);
    end
    op(SP, 8'h00);
    polls = 0;
    do
    begin
      op(ST, 8'h00);
      op(i2sp_pkg::OP_WRITE, WA);
      if (got_nack === 1'b1)
        polls++;
      if (got_nack === 1'b1)
        op(SP, 8'h00);
    end
    while (got_nack === 1'b1 && polls < 40);
    op(SP, 8'h00);
    check(8'(polls > 0), 8'h01);
    check({7'h00, got_nack}, 8'h00);
  endtask : burst

  // Point counter at a, then read n bytes; rs picks repeated start
  task automatic rd(input logic [5:0] a, input int n, input logic rs);
    rq.delete();
    op(ST, 8'h00);
    wb(WA, 1'b0);
    wb({2'b00, a}, 1'b0);
    if (!rs)
      op(SP, 8'h00);
    op(ST, 8'h00);
    wb(RA, 1'b0);
    for (int i = 0; i < n; i++)
      op((i == n - 1) ? RN : RK, 8'h00);
    op(SP, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < n; i++)
      check(pop(), mem[6'(int'(a) + i)]);
  endtask : rd

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // Watchdog
  initial
  begin
    #600000;
    n_fail++;
    $display("ERROR at %0t: watchdog expired", $time);
    final_report();
  end

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    busy_seen = 1'b0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_data = 8'h00;
    rd_ready = 1'b1;
    foreach (mem[i])
      mem[i] = 8'h00;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    // Row wrap, busy polling, dummy-write reads
    burst(6'h06, 3, 8'h11);
    rd(6'h06, 3, 1'b1);
    rd(6'h00, 1, 1'b1);
    $display("Test wrap finished");
    // Next row after a stop, current-address read
    burst(6'h08, 1, 8'h44);
    rd(6'h06, 3, 1'b0);
    burst(6'h10, 8, 8'h01);
    rd(6'h10, 8, 1'b1);
    $display("Test rows finished");
    // Foreign address ignored; repeated start drops the commit
    busy_seen = 1'b0;
    op(ST, 8'h00);
    wb(8'ha0, 1'b1);
    wb(WA, 1'b1);
    op(SP, 8'h00);
    rq.delete();
    op(ST, 8'h00);
    wb(WA, 1'b0);
    wb(8'h20, 1'b0);
    wb(8'h5a, 1'b0);
    mem[32] = 8'h5a;
    op(ST, 8'h00);
    wb(RA, 1'b0);
    op(RN, 8'h00);
    op(SP, 8'h00);
    repeat (NVW + 50) @(posedge clk);
    #1;
    check({7'h00, busy_seen}, 8'h00);
    check(pop(), mem[33]);
    $display("Test abort finished");
    // Full read buffer holds the next operation
    rq.delete();
    op(ST, 8'h00);
    wb(WA, 1'b0);
    wb(8'h06, 1'b0);
    op(ST, 8'h00);
    wb(RA, 1'b0);
    rd_ready = 1'b0;
    op(RK, 8'h00);
    op(RK, 8'h00);
    fork
      op(RN, 8'h00);
      begin
        // Longer than one whole operation, so an unblocked host would be ready again
        repeat (250) @(posedge clk);
        check({7'h00, cmd_ready}, 8'h00);
        check(rd_data, mem[6]);
        #1 rd_ready = 1'b1;
      end
    join
    op(SP, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    for (int i = 6; i < 9; i++)
      check(pop(), mem[i]);
    $display("Test buffer finished");
    final_report();
  end
endmodule : testbench
